// ===== logic/mesf_event_flags.sv
// module: metering event status word, change flags and enables behind an Avalon-MM slave
// Functional notes
// - state bit 15 high while frequency above high
// - state bit 11 high while frequency below low
// - bits 14..12 show sag on A, B, C
// - bits 10..8 show phase loss A, B, C
// - bit 7 is total reactive sign, 1 negative
// - bits 6..4 are phase reactive signs
// - bit 3 is total active sign, 1 negative
// - bits 2..0 are phase active signs
// - flags0 15..13 on overcurrent change A, B, C
// - flags0 12..10 on overvoltage change A, B, C
// - flags0 9, 8 on sequence error changes
// - flags0 7 on neutral overcurrent change
// - flags0 6..4 on no-load status changes
// - flags0 3..0 on pulse output direction changes
// - flags1 14..12 on sag changes
// - flags1 10..8 on phase loss changes
// - flags1 7..4 on reactive sign changes
// - flags1 3..0 on active sign changes
// - interrupt only where enable bit set
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps

module mesf_event_flags (
    // clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    // live conditions
    input  wire mesf_pkg::mesf_cond_one_s i_cond_one,
    input  wire mesf_pkg::mesf_cond_two_s i_cond_two,
    // avalon-mm slave
    input  wire logic [5:0]             i_avs_address,
    input  wire logic                   i_avs_read,
    input  wire logic                   i_avs_write,
    input  wire logic [31:0]            i_avs_writedata,
    input  wire logic [3:0]             i_avs_byteenable,
    output logic                        o_avs_waitrequest,
    output logic [31:0]                 o_avs_readdata,
    // status and interrupt
    output logic [15:0]                 o_state_two,
    output logic                        o_irq
);

    mesf_pkg::mesf_state_s state_reg;
    mesf_pkg::mesf_state_s state_next;

    logic [15:0] raw_two;
    logic [15:0] raw_one;
    logic [15:0] change_zero;
    logic [15:0] change_one;
    logic [15:0] wmask;
    logic [15:0] clr_zero;
    logic [15:0] clr_one;
    logic [15:0] wen_data;
    logic [3:0]  idx;
    logic        word_ok;
    logic        do_write;
    logic        do_read;

    // pack the live conditions into word layout
    always_comb
    begin
        raw_two = mesf_pkg::RST_WORD;
        raw_two[mesf_pkg::POS_FREQ_HIGH] = i_cond_two.freq_above_high_status;
        raw_two[mesf_pkg::POS_FREQ_LOW]  = i_cond_two.freq_below_low_status;
        raw_two[mesf_pkg::POS_SAG_A]     = i_cond_two.sag_status[2];
        raw_two[mesf_pkg::POS_SAG_B]     = i_cond_two.sag_status[1];
        raw_two[mesf_pkg::POS_SAG_C]     = i_cond_two.sag_status[0];
        raw_two[mesf_pkg::POS_LOSS_A]    = i_cond_two.loss_status[2];
        raw_two[mesf_pkg::POS_LOSS_B]    = i_cond_two.loss_status[1];
        raw_two[mesf_pkg::POS_LOSS_C]    = i_cond_two.loss_status[0];
        raw_two[mesf_pkg::POS_TOTAL_Q]   = i_cond_two.total_reactive_sign;
        raw_two[mesf_pkg::POS_Q_A]       = i_cond_two.reactive_sign[2];
        raw_two[mesf_pkg::POS_Q_B]       = i_cond_two.reactive_sign[1];
        raw_two[mesf_pkg::POS_Q_C]       = i_cond_two.reactive_sign[0];
        raw_two[mesf_pkg::POS_TOTAL_P]   = i_cond_two.total_active_sign;
        raw_two[mesf_pkg::POS_P_A]       = i_cond_two.active_sign[2];
        raw_two[mesf_pkg::POS_P_B]       = i_cond_two.active_sign[1];
        raw_two[mesf_pkg::POS_P_C]       = i_cond_two.active_sign[0];
        // word one layout matches the struct order: bit 15 down to bit 0
        raw_one = i_cond_one;
    end

    // change detection against the previous cycle, both directions
    assign change_zero = state_reg.primed ? (state_reg.state_one ^ state_reg.prev_one)
                                          : 16'h0000;
    assign change_one  = state_reg.primed ? (state_reg.state_two ^ state_reg.prev_two)
                                          : 16'h0000;

    // bus decode
    assign idx      = i_avs_address[5:2];
    assign word_ok  = (i_avs_address[1:0] == 2'h0);
    assign do_write = i_avs_write && !i_avs_read && !state_reg.readdatavalid;
    assign do_read  = i_avs_read && !i_avs_write && !state_reg.readdatavalid;
    assign wmask    = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    assign wen_data = i_avs_writedata[15:0] & wmask;

    always_comb
    begin
        clr_zero = 16'h0000;
        clr_one  = 16'h0000;
        if (do_write && word_ok && idx == mesf_pkg::IDX_FLAGS_ZERO)
        begin
            clr_zero = wen_data;
        end
        else if (do_write && word_ok && idx == mesf_pkg::IDX_FLAGS_ONE)
        begin
            clr_one = wen_data;
        end
    end

    always_comb
    begin
        state_next               = state_reg;
        state_next.readdatavalid = 1'b0;
        // two-stage capture of asynchronous conditions
        state_next.sync_one  = raw_one;
        state_next.sync_two  = raw_two;
        state_next.state_one = state_reg.sync_one;
        state_next.state_two = state_reg.sync_two;
        state_next.prev_one  = state_reg.state_one;
        state_next.prev_two  = state_reg.state_two;
        state_next.primed    = 1'b1;
        // flags: set wins over clear
        state_next.flags_zero = (state_reg.flags_zero & ~clr_zero) | change_zero;
        state_next.flags_one  = (state_reg.flags_one & ~clr_one) | change_one;
        if (do_write && word_ok && idx == mesf_pkg::IDX_ENABLE_ZERO)
        begin
            state_next.enable_zero = (state_reg.enable_zero & ~wmask) | wen_data;
        end
        else if (do_write && word_ok && idx == mesf_pkg::IDX_ENABLE_ONE)
        begin
            state_next.enable_one = (state_reg.enable_one & ~wmask) | wen_data;
        end
        if (do_read)
        begin
            state_next.readdatavalid = 1'b1;
            state_next.readdata      = mesf_pkg::READ_ZERO;
            if (!word_ok)
            begin
                state_next.readdata = mesf_pkg::READ_ZERO;
            end
            else if (idx == mesf_pkg::IDX_STATE_ONE)
            begin
                state_next.readdata = {16'h0000, state_reg.state_one};
            end
            else if (idx == mesf_pkg::IDX_STATE_TWO)
            begin
                state_next.readdata = {16'h0000, state_reg.state_two};
            end
            else if (idx == mesf_pkg::IDX_FLAGS_ZERO)
            begin
                state_next.readdata = {16'h0000, state_reg.flags_zero};
            end
            else if (idx == mesf_pkg::IDX_FLAGS_ONE)
            begin
                state_next.readdata = {16'h0000, state_reg.flags_one};
            end
            else if (idx == mesf_pkg::IDX_ENABLE_ZERO)
            begin
                state_next.readdata = {16'h0000, state_reg.enable_zero};
            end
            else if (idx == mesf_pkg::IDX_ENABLE_ONE)
            begin
                state_next.readdata = {16'h0000, state_reg.enable_one};
            end
        end
        state_next.irq = |(state_next.flags_zero & state_next.enable_zero)
                       | |(state_next.flags_one & state_next.enable_one);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // read answered one cycle after request; write taken at once
    assign o_avs_waitrequest = i_avs_read && !state_reg.readdatavalid;
    assign o_avs_readdata    = state_reg.readdata;
    assign o_state_two       = state_reg.state_two;
    assign o_irq             = state_reg.irq;

endmodule : mesf_event_flags

// ===== logic/mesf_pkg.sv
// package: register map, field positions and carriers of the metering event flag block
package mesf_pkg;

    localparam int unsigned ADDR_W = 4;

    // word offsets (byte address = 4 * index)
    localparam logic [ADDR_W-1:0] IDX_STATE_ONE  = 4'h0;
    localparam logic [ADDR_W-1:0] IDX_STATE_TWO  = 4'h1;
    localparam logic [ADDR_W-1:0] IDX_FLAGS_ZERO = 4'h2;
    localparam logic [ADDR_W-1:0] IDX_FLAGS_ONE  = 4'h3;
    localparam logic [ADDR_W-1:0] IDX_ENABLE_ZERO = 4'h4;
    localparam logic [ADDR_W-1:0] IDX_ENABLE_ONE = 4'h5;

    // reset values
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // state word two field positions
    localparam int unsigned POS_FREQ_HIGH  = 15;
    localparam int unsigned POS_SAG_A      = 14;
    localparam int unsigned POS_SAG_B      = 13;
    localparam int unsigned POS_SAG_C      = 12;
    localparam int unsigned POS_FREQ_LOW   = 11;
    localparam int unsigned POS_LOSS_A     = 10;
    localparam int unsigned POS_LOSS_B     = 9;
    localparam int unsigned POS_LOSS_C     = 8;
    localparam int unsigned POS_TOTAL_Q    = 7;
    localparam int unsigned POS_Q_A        = 6;
    localparam int unsigned POS_Q_B        = 5;
    localparam int unsigned POS_Q_C        = 4;
    localparam int unsigned POS_TOTAL_P    = 3;
    localparam int unsigned POS_P_A        = 2;
    localparam int unsigned POS_P_B        = 1;
    localparam int unsigned POS_P_C        = 0;

    // live conditions entering the block
    typedef struct packed {
        logic       freq_above_high_status;
        logic [2:0] sag_status;          // a, b, c
        logic       freq_below_low_status;
        logic [2:0] loss_status;         // a, b, c
        logic       total_reactive_sign;
        logic [2:0] reactive_sign;       // a, b, c
        logic       total_active_sign;
        logic [2:0] active_sign;         // a, b, c
    } mesf_cond_two_s;

    typedef struct packed {
        logic [2:0] overcurrent;         // a, b, c
        logic [2:0] overvoltage;         // a, b, c
        logic       voltage_sequence_err;
        logic       current_sequence_err;
        logic       neutral_overcurrent;
        logic       reactive_noload;
        logic       active_noload;
        logic       apparent_noload;
        logic [3:0] pulse_out_reverse;   // outputs 1..4
    } mesf_cond_one_s;

    typedef struct packed {
        logic [15:0] sync_one;
        logic [15:0] sync_two;
        logic [15:0] state_one;
        logic [15:0] state_two;
        logic [15:0] prev_one;
        logic [15:0] prev_two;
        logic        primed;
        logic [15:0] flags_zero;
        logic [15:0] flags_one;
        logic [15:0] enable_zero;
        logic [15:0] enable_one;
        logic [31:0] readdata;
        logic        readdatavalid;
        logic        irq;
    } mesf_state_s;

endpackage : mesf_pkg

// ===== testbench/mesf_event_flags_monitor.sv
// checker: port timing relations of the metering event flag block
`timescale 1ns/1ps
module mesf_event_flags_monitor (
    // clock and reset
    input wire logic                     i_clk,
    input wire logic                     i_rst,
    // conditions and bus
    input wire mesf_pkg::mesf_cond_one_s i_cond_one,
    input wire mesf_pkg::mesf_cond_two_s i_cond_two,
    input wire logic [5:0]               i_avs_address,
    input wire logic                     i_avs_read,
    input wire logic                     i_avs_write,
    input wire logic [31:0]              i_avs_writedata,
    input wire logic [3:0]               i_avs_byteenable,
    // outputs watched
    input wire logic                     o_avs_waitrequest,
    input wire logic [31:0]              o_avs_readdata,
    input wire logic [15:0]              o_state_two,
    input wire logic                     o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_state_delay:
        assert property (!$past(i_rst) && !$past(i_rst, 2) && !$past(i_rst, 3)
            |-> o_state_two == $past(i_cond_two, 2)) else $error("state word wrong");
    a_irq_rise_cause:
        assert property ($rose(o_irq) |-> $past(i_avs_write) || $past(i_avs_write, 2)
            || $past(o_state_two) != $past(o_state_two, 2)
            || $past(i_cond_one, 3) != $past(i_cond_one, 4)) else $error("irq rose uncaused");
    a_irq_fall_cause:
        assert property ($fell(o_irq) |-> $past(i_avs_write) || $past(i_avs_write, 2))
            else $error("irq fell without a write");
    a_irq_hold:
        assert property (o_irq && !i_avs_write && !$past(i_avs_write) |=> o_irq)
            else $error("irq dropped by itself");
    a_read_wait:
        assert property ($rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
            else $error("read answer timing wrong");
    a_write_nowait:
        assert property (i_avs_write |-> !o_avs_waitrequest) else $error("write stalled");
    a_state_readback:
        assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == 6'h04
            |-> o_avs_readdata == {16'h0000, $past(o_state_two)}) else $error("bad readback");
    a_unmapped_zero:
        assert property (i_avs_read && !o_avs_waitrequest
            && (i_avs_address[1:0] != 2'h0 || i_avs_address >= 6'h18)
            |-> o_avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
    cover property ($rose(o_irq));
    cover property (i_avs_write && i_avs_address == 6'h0C);
    cover property (i_avs_read && !o_avs_waitrequest && i_avs_address == 6'h08);
endmodule : mesf_event_flags_monitor
bind mesf_event_flags mesf_event_flags_monitor mesf_event_flags_monitor_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_cond_one(i_cond_one), .i_cond_two(i_cond_two),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata),
    .o_state_two(o_state_two), .o_irq(o_irq));

// ===== testbench/mesf_event_flags_tb.sv
// testbench: register walk of the metering event flag block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module mesf_event_flags_tb;
    logic        clk;
    logic        rst;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [5:0]  addr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdata;
    logic [3:0]  ben;
    logic        waitreq;
    logic [31:0] rdata;
    logic [15:0] state_two;
    logic        irq;
    logic [31:0] got;
    int          mismatches;
    int          total_checks;
    mesf_event_flags mesf_event_flags_i (
        .i_clk(clk), .i_rst(rst),
        .i_cond_one(mesf_pkg::mesf_cond_one_s'(c1)), .i_cond_two(mesf_pkg::mesf_cond_two_s'(c2)),
        .i_avs_address(addr), .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
        .i_avs_byteenable(ben), .o_avs_waitrequest(waitreq), .o_avs_readdata(rdata),
        .o_state_two(state_two), .o_irq(irq));
    task automatic final_report();
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic bus(input logic [5:0] a, input logic w, input logic [15:0] d);
        int n;
        @(posedge clk);
        addr <= a;
        wr_en <= w;
        rd_en <= !w;
        wdata <= {16'h0000, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        got = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        if (n >= 20)
        begin
            mismatches++;
            final_report();
        end
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        bus(a, 1'b0, 16'h0000);
        `CHK("readdata", {16'h0000, e}, got)
    endtask : rd
    task automatic set_cond(input bit w, input logic [15:0] v);
        @(posedge clk);
        if (w) c2 <= v;
        else c1 <= v;
        repeat (6) @(posedge clk);
    endtask : set_cond
    task automatic walk(input bit w);
        logic [5:0]  fa;
        logic [15:0] b;
        fa = w ? 6'h0C : 6'h08;
        for (int i = 0; i < 16; i++)
        begin
            b = 16'h0001 << i;
            set_cond(w, b);
            `CHK("state_two", w ? b : 16'h0000, state_two)
            if (!w) rd(6'h00, b);
            if (w) rd(6'h04, b);
            rd(fa, b);
            bus(fa, 1'b1, 16'h0000);
            rd(fa, b);
            bus(fa, 1'b1, 16'hFFFF);
            set_cond(w, 16'h0000);
            rd(fa, b);
            bus(fa, 1'b1, 16'hFFFF);
            rd(fa, 16'h0000);
        end
    endtask : walk
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        rst = 1'b1;
        {c1, c2, addr, rd_en, wr_en, wdata} = '0;
        ben = 4'h3;
        mismatches = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 6; a++) rd(6'(a * 4), 16'h0000);
        rd(6'h18, 16'h0000);
        rd(6'h06, 16'h0000);
        bus(6'h04, 1'b1, 16'hFFFF);
        rd(6'h04, 16'h0000);
        walk(1'b0);
        walk(1'b1);
        set_cond(1'b1, 16'h8000);
        `CHK("irq", 1'b0, irq)
        bus(6'h14, 1'b1, 16'h8000);
        rd(6'h14, 16'h8000);
        `CHK("irq", 1'b1, irq)
        bus(6'h0C, 1'b1, 16'hFFFF);
        rd(6'h0C, 16'h0000);
        `CHK("irq", 1'b0, irq)
        @(posedge clk);
        c1 <= 16'h0001;
        @(posedge clk);
        bus(6'h08, 1'b1, 16'h0001);
        rd(6'h08, 16'h0001);
        bus(6'h10, 1'b1, 16'h0001);
        rd(6'h10, 16'h0001);
        `CHK("irq", 1'b1, irq)
        bus(6'h08, 1'b1, 16'h0001);
        rd(6'h08, 16'h0000);
        `CHK("irq", 1'b0, irq)
        ben <= 4'h2;
        bus(6'h10, 1'b1, 16'hFFFF);
        ben <= 4'h3;
        rd(6'h10, 16'hFF01);
        final_report();
    end
endmodule : mesf_event_flags_tb
